// ==== logic/decs_ctrl.v ====
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "decs_defs.vh"
module decs_ctrl #(
	parameter ARRAY_CYCLES = 16,
	parameter LONG_CYCLES  = `DECS_LONG_MS * `DECS_CLK_KHZ
) (
	input  wire        clock_in,
	input  wire        reset_in,
	input  wire        por_in,
	input  wire        brownout_reset_in,
	input  wire        verify_fail_in,
	input  wire [3:0]  addr_in,
	input  wire [31:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [31:0] rdata_out,
	output reg         irq_out,
	output reg         busy_out
);
	reg  [2:0]  task_code;
	reg  [1:0]  fault;
	reg         lwp;
	reg         wperm;
	reg         go;
	reg         enable;
	reg  [31:0] word_pointer;
	reg  [2:0]  stat;
	reg  [2:0]  mask;
	reg         start;
	reg         bo_s1;
	reg         bo_s2;
	reg         bo_d;
	wire        arr_done;
	wire        arr_fail;
	wire        bo_event;
	wire        wr_ctl;
	wire        bad_cmd;
	wire        wr_ptr;
	wire        wr_stat;
	wire        wr_mask;
	wire        verify_err;
	wire [2:0]  stat_set;
	wire [2:0]  next_stat;
	genvar      sb;

	// write tasks need write permit, reads need it clear
	function cmd_ok;
		input [2:0] code;
		input       perm;
		begin
			if (code == `DECS_TASK_READ)
				cmd_ok = !perm;
			else if (code <= `DECS_TASK_CFG)
				cmd_ok = perm;
			else
				cmd_ok = 1'b0;
		end
	endfunction

	// one register picked by a strobe at its offset
	function reg_hit;
		input       strobe;
		input [3:0] addr;
		input [3:0] offset;
		begin
			reg_hit = strobe && addr == offset;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// brown-out flag is asynchronous, synchronise first
	always @(posedge clock_in) begin
		if (reset_in) begin
			bo_s1 <= 1'b0;
			bo_s2 <= 1'b0;
			bo_d  <= 1'b0;
		end else begin
			bo_s1 <= brownout_reset_in;
			bo_s2 <= bo_s1;
			bo_d  <= bo_s2;
		end
	end
	assign bo_event = bo_s2 && !bo_d;
	// register write selects
	assign wr_ctl   = reg_hit(wr_in, addr_in, `DECS_OFF_CTL);
	assign wr_ptr   = reg_hit(wr_in, addr_in, `DECS_OFF_ADDR);
	assign wr_stat  = reg_hit(wr_in, addr_in, `DECS_OFF_STAT);
	assign wr_mask  = reg_hit(wr_in, addr_in, `DECS_OFF_MASK);
	// code and permit arrive with go, so check the written ones, not the stored ones
	assign bad_cmd  = !cmd_ok(wdata_in[`DECS_CMD_MSB:`DECS_CMD_LSB],
		wdata_in[`DECS_WPERM_BIT]) || word_pointer[1:0] != 2'h0;
	// read and configuration write never report a verify fault
	assign verify_err = arr_done && arr_fail && task_code != `DECS_TASK_READ
		&& task_code != `DECS_TASK_CFG;

	////////////////////////////////////////////////////////////////////
	// task code survives every reset but power-on
	always @(posedge clock_in) begin
		if (por_in) begin
			task_code <= `DECS_TASK_READ;
		end else if (wr_ctl && !go) begin
			task_code <= wdata_in[`DECS_CMD_MSB:`DECS_CMD_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////
	// control, fault code and long-write flag
	always @(posedge clock_in) begin
		if (reset_in || por_in) begin
			fault        <= `DECS_ERR_NONE;
			lwp          <= 1'b0;
			wperm        <= 1'b0;
			go           <= 1'b0;
			enable       <= 1'b0;
			start        <= 1'b0;
			word_pointer <= 32'h0;
		end else begin
			start <= 1'b0;
			if (wr_ctl) begin
				enable <= wdata_in[`DECS_EN_BIT];
				wperm  <= wdata_in[`DECS_WPERM_BIT];
				// fault writable only while idle, no side effect
				if (!go)
					fault <= wdata_in[`DECS_ERR_MSB:`DECS_ERR_LSB];
				if (!wdata_in[`DECS_LWP_BIT])
					lwp <= 1'b0;
			end
			if (wr_ptr) begin
				word_pointer <= wdata_in;
				lwp          <= 1'b0;
			end
			// go request: check first, invalid ends at once
			if (wr_ctl && wdata_in[`DECS_GO_BIT] && !go && enable) begin
				if (bad_cmd) begin
					fault <= `DECS_ERR_INVALID;
				end else begin
					go    <= 1'b1;
					start <= 1'b1;
				end
			end
			if (arr_done) begin
				go <= 1'b0;
				if (verify_err)
					fault <= `DECS_ERR_VERIFY;
				else
					fault <= `DECS_ERR_NONE;
				if (task_code == `DECS_TASK_WORD)
					lwp <= 1'b1;
			end
			if (!enable && !(wr_ctl && wdata_in[`DECS_EN_BIT]))
				fault <= `DECS_ERR_NONE;
			// brown-out outranks every other code
			if (bo_event)
				fault <= `DECS_ERR_BROWN;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky status: done, fault, brownout; set beats clear
	// fail bit follows verify faults only; an invalid-task fault sets the fault code but no status bit
	assign stat_set = {bo_event, verify_err, arr_done};
	generate
		for (sb = 0; sb < `DECS_IRQ_W; sb = sb + 1) begin : g_stat
			// write one to clear; an event in the same cycle wins
			assign next_stat[sb] = stat_set[sb] | (stat[sb] & ~(wr_stat & wdata_in[sb]));
		end
	endgenerate

	always @(posedge clock_in) begin
		if (reset_in || por_in) begin
			stat      <= 3'h0;
			mask      <= 3'h0;
			irq_out   <= 1'b0;
			busy_out  <= 1'b0;
			rdata_out <= 32'h0;
		end else begin
			stat <= next_stat;
			if (wr_mask)
				mask <= wdata_in[2:0];
			irq_out  <= |(next_stat & mask);
			busy_out <= go || start;
			rdata_out <= 32'h0;
			if (rd_in) begin
				case (addr_in)
				`DECS_OFF_CTL: begin
					rdata_out <= {16'h0, enable, wperm, go, 7'h0, fault, lwp, task_code};
				end
				`DECS_OFF_ADDR: begin
					rdata_out <= word_pointer;
				end
				`DECS_OFF_STAT: begin
					rdata_out <= {29'h0, stat};
				end
				`DECS_OFF_MASK: begin
					rdata_out <= {29'h0, mask};
				end
				default: begin
					rdata_out <= 32'h0;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	decs_array #(
		.CYCLES(ARRAY_CYCLES)
	) u_array (
		.clock_in       (clock_in),
		.reset_in       (reset_in | por_in),
		.start_in       (start),
		.verify_fail_in (verify_fail_in),
		.done_out       (arr_done),
		.fail_out       (arr_fail)
	);
endmodule

// ==== logic/decs_defs.vh ====
`ifndef DECS_DEFS_VH
`define DECS_DEFS_VH
// register byte offsets
`define DECS_OFF_CTL      4'h0
`define DECS_OFF_ADDR     4'h4
`define DECS_OFF_STAT     4'h8
`define DECS_OFF_MASK     4'hc
// control word fields
`define DECS_CMD_LSB      0
`define DECS_CMD_MSB      2
`define DECS_LWP_BIT      3
`define DECS_ERR_LSB      4
`define DECS_ERR_MSB      5
`define DECS_WPERM_BIT    14
`define DECS_GO_BIT       13
`define DECS_EN_BIT       15
// task codes
`define DECS_TASK_READ    3'h0
`define DECS_TASK_WORD    3'h1
`define DECS_TASK_PAGE    3'h2
`define DECS_TASK_BULK    3'h3
`define DECS_TASK_CFG     3'h4
// fault codes
`define DECS_ERR_NONE     2'h0
`define DECS_ERR_VERIFY   2'h1
`define DECS_ERR_INVALID  2'h2
`define DECS_ERR_BROWN    2'h3
// status bits: done, fault, brownout
`define DECS_IRQ_W        3
`define DECS_ARR_W        4
// long write time
`define DECS_LONG_MS      20
`define DECS_CLK_KHZ      100000
`endif

// ==== logic/decs_array.v ====
`timescale 1ns/1ps
`include "decs_defs.vh"
// stand-in for the array sequencer: busy count, registered answer
module decs_array #(
	parameter CYCLES = 16
) (
	input  wire       clock_in,
	input  wire       reset_in,
	input  wire       start_in,
	input  wire       verify_fail_in,
	output reg        done_out,
	output reg        fail_out
);
	reg [31:0] count;
	reg        busy;
	reg        fail_hold;
	// counts down the operation, then pulses done with its outcome
	always @(posedge clock_in) begin
		if (reset_in) begin
			count     <= 32'h0;
			busy      <= 1'b0;
			fail_hold <= 1'b0;
			done_out  <= 1'b0;
			fail_out  <= 1'b0;
		end else begin
			done_out <= 1'b0;
			fail_out <= 1'b0;
			if (start_in && !busy) begin
				busy      <= 1'b1;
				count     <= CYCLES - 1;
				fail_hold <= verify_fail_in;
			end else if (busy) begin
				if (count == 32'h0) begin
					busy     <= 1'b0;
					done_out <= 1'b1;
					fail_out <= fail_hold;
				end else begin
					count <= count - 32'h1;
				end
			end
		end
	end
endmodule

// ==== sim/decs_ctrl_props.sv ====
`timescale 1ns/1ps
// port-level checker for the command and status block
module decs_props (
	input wire        clock_in,
	input wire        reset_in,
	input wire        por_in,
	input wire        brownout_reset_in,
	input wire        verify_fail_in,
	input wire [3:0]  addr_in,
	input wire [31:0] wdata_in,
	input wire        wr_in,
	input wire        rd_in,
	input wire [31:0] rdata_out,
	input wire        irq_out,
	input wire        busy_out
);
	reg [2:0] cmd_q;
	reg [2:0] mask_q;
	reg [1:0] ptr_low;
	////////////////////////////////////////////////////////////////
	// shadows of software writes; the task code outlives system reset
	always @(posedge clock_in) begin
		if (por_in)
			cmd_q <= 3'h0;
		else if (wr_in && addr_in == 4'h0 && !busy_out)
			cmd_q <= wdata_in[2:0];
		if (por_in || reset_in) begin
			mask_q  <= 3'h0;
			ptr_low <= 2'h0;
		end else if (wr_in) begin
			if (addr_in == 4'hc) mask_q <= wdata_in[2:0];
			if (addr_in == 4'h4) ptr_low <= wdata_in[1:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in || por_in);
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data not zero outside read answer");
	a_go_ends: assert property ($rose(busy_out) |-> ##[1:8] !busy_out)
		else $error("task did not finish in time");
	a_go_cause: assert property ($rose(busy_out) |-> $past(wr_in) || $past(wr_in, 2))
		else $error("busy rose without a write");
	a_bad_no_go: assert property (!busy_out && wr_in && addr_in == 4'h0 && wdata_in[13]
		&& (wdata_in[2:0] > 3'h4 || ptr_low != 2'h0) |=> !busy_out [*3])
		else $error("invalid task was started");
	a_por_clear: assert property ($fell(por_in) |-> !busy_out && !irq_out)
		else $error("outputs not clear after reset");
	a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_out)
		else $error("interrupt raised while masked");
	a_lwp_ptr: assert property (wr_in && addr_in == 4'h4 && !busy_out ##2
		rd_in && addr_in == 4'h0 |=> !rdata_out[3])
		else $error("long write flag kept after pointer write");
	a_cmd_kept: assert property (rd_in && addr_in == 4'h0 |=> rdata_out[2:0] == $past(cmd_q))
		else $error("task code not as written");
	c_task: cover property ($fell(busy_out));
	c_irq: cover property ($rose(irq_out));
	c_brown: cover property ($rose(brownout_reset_in));
endmodule

// ==== sim/decs_ctrl_tb.sv ====
`timescale 1ns/1ps
module decs_ctrl_tb;
	reg         clock_in = 0, reset_in = 1, por_in = 1, brownout_reset_in = 0;
	reg         verify_fail_in = 0, wr_in = 0, rd_in = 0;
	reg  [3:0]  addr_in = 4'h0;
	reg  [31:0] wdata_in = 32'h0, got;
	wire [31:0] rdata_out;
	wire        irq_out, busy_out;
	integer     bad_count = 0, comparisons = 0, seed = 32'h55d94a25, i, c;
	integer     cmd = 0, lwp = 0, flt = 0, mis = 0;
	// free-running system clock
	always #5 clock_in = ~clock_in;
	decs_ctrl #(.ARRAY_CYCLES(4)) dut (.clock_in(clock_in), .reset_in(reset_in),
		.por_in(por_in), .brownout_reset_in(brownout_reset_in),
		.verify_fail_in(verify_fail_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
		.busy_out(busy_out));
	////////////////////////////////////////////////////////////////
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge clock_in); addr_in <= a; wdata_in <= d; wr_in <= 1;
			@(posedge clock_in); wr_in <= 0;
		end
	endtask
	// data is looked at in the one cycle it stands
	task rd(input [3:0] a);
		begin
			@(posedge clock_in); addr_in <= a; rd_in <= 1;
			@(posedge clock_in); rd_in <= 0;
			#1 got = rdata_out;
		end
	endtask
	task chk(input [23:0] n, input [31:0] e, input [31:0] s);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED %0s expected %h seen %h", n, e, s);
			end
		end
	endtask
	// bounded wait: busy may need a cycle to show
	task wait_done;
		for (i = 0; i < 40 && (i < 2 || busy_out !== 1'b0); i = i + 1) @(posedge clock_in);
	endtask
	task rdc;
		begin
			rd(4'h0);
			chk("ctl", 32'hc000 | cmd | lwp << 3 | flt << 4, got);
		end
	endtask
	// start a task; model: a control write with bit 3 clear drops the long-write flag
	task op(input integer k, input integer vf);
		begin
			verify_fail_in <= vf[0];
			cmd = k;
			wr(4'h0, 32'he000 | k);
			wait_done;
			flt = (k > 4 || mis) ? 2 : (k == 4 ? 0 : vf[0]);
			lwp = (k == 1 && !mis);
			rdc;
			if (k < 5) chk("irq", flt == 1, irq_out);
			wr(4'h8, 32'h7);
		end
	endtask
	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, bad_count);
			if (bad_count == 0 && comparisons > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge clock_in);
		reset_in <= 0; por_in <= 0;
		wr(4'hc, 32'h2);
		wr(4'h0, 32'hc000);
		op(4, 0);
		for (c = 1; c < 8; c = c + 1) op(c, $random(seed));
		// word read: code 000 with write permit clear, no fault, no interrupt
		wr(4'h0, 32'h8000);
		wr(4'h0, 32'ha000);
		wait_done;
		rd(4'h0); chk("ctl", 32'h8000, got);
		chk("irq", 0, irq_out);
		$display("end task codes");
		wr(4'h4, 32'h1); mis = 1;
		op(1, 0);
		wr(4'h4, 32'h0); mis = 0; lwp = 0;
		op(1, 0);
		wr(4'h4, 32'h0); lwp = 0;
		rdc;
		wr(4'h0, 32'hc031); flt = 3;
		rdc;
		chk("bsy", 0, busy_out);
		wr(4'h0, 32'h4031);
		rd(4'h0); chk("ctl", 32'h4001, got);
		$display("end fault field");
		wr(4'h0, 32'hc000);
		wr(4'h0, 32'he001);
		wr(4'h0, 32'hc002);
		wait_done;
		rd(4'h0); chk("cmd", 1, got & 7);
		@(posedge clock_in) reset_in <= 1;
		@(posedge clock_in) reset_in <= 0;
		rd(4'h0); chk("cmd", 1, got & 7);
		@(posedge clock_in) por_in <= 1;
		@(posedge clock_in) por_in <= 0;
		rd(4'h0); chk("cmd", 0, got & 7);
		$display("end resets");
		wr(4'hc, 32'h4);
		// enable first: a disabled module clears the fault code at once
		wr(4'h0, 32'h8000);
		@(posedge clock_in) brownout_reset_in <= 1;
		repeat (3) @(posedge clock_in);
		brownout_reset_in <= 0;
		repeat (4) @(posedge clock_in);
		rd(4'h0); chk("flt", 3, got[5:4]);
		chk("irq", 1, irq_out);
		wr(4'h8, 32'h4);
		repeat (2) @(posedge clock_in);
		chk("irq", 0, irq_out);
		rd(4'h2); chk("map", 0, got);
		$display("end brownout and map");
		end_sim;
	end
	// cut a hang short
	initial begin
		#100000;
		bad_count = bad_count + 1;
		end_sim;
	end
endmodule
bind decs_ctrl decs_props chk (.clock_in(clock_in), .reset_in(reset_in), .por_in(por_in),
	.brownout_reset_in(brownout_reset_in), .verify_fail_in(verify_fail_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .irq_out(irq_out), .busy_out(busy_out));
